// ===== byte_arith.sv
`timescale 1ns/1ps
// combinational byte arithmetic: xor, add/subtract with carry, divide
module byte_arith (
  input wire logic [1:0] i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_carry,
  output logic [7:0] o_res,
  output logic [7:0] o_aux,
  output logic o_carry,
  output logic o_aux_carry,
  output logic o_ovf
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] lo7;
  logic c6;
  // --------------------------------------------------------------
  // operation select
  // --------------------------------------------------------------
  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    lo7 = 8'h00;
    c6 = 1'b0;
    o_res = i_a;
    o_aux = i_b;
    o_carry = i_carry;
    o_aux_carry = 1'b0;
    o_ovf = 1'b0;
    case (i_op)
      xor_alu_pkg::ALU_XOR: begin
        o_res = i_a ^ i_b;
      end
      xor_alu_pkg::ALU_ADD_WITH_CARRY: begin
        sum9 = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry};
        sum5 = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_carry};
        lo7 = {1'b0, i_a[6:0]} + {1'b0, i_b[6:0]} + {7'h00, i_carry};
        c6 = lo7[7];
        o_res = sum9[7:0];
        o_carry = sum9[8];
        o_aux_carry = sum5[4];
        o_ovf = sum9[8] ^ c6;
      end
      xor_alu_pkg::ALU_SUBTRACT_WITH_BORROW: begin
        sum9 = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_carry};
        sum5 = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_carry};
        lo7 = {1'b0, i_a[6:0]} - {1'b0, i_b[6:0]} - {7'h00, i_carry};
        c6 = lo7[7];
        o_res = sum9[7:0];
        o_carry = sum9[8];
        o_aux_carry = sum5[4];
        o_ovf = sum9[8] ^ c6;
      end
      default: begin
        if (i_b == xor_alu_pkg::BYTE_ZERO) begin
          o_ovf = 1'b1;
        end else begin
          o_res = i_a / i_b;
          o_aux = i_a % i_b;
        end
        o_carry = 1'b0;
      end
    endcase
  end
endmodule

// ===== xor_alu_pkg.sv
package xor_alu_pkg;
  // ----------------------------------------------------------------
  // opcodes of the exclusive-or forms
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_XOR_A_BANK = 8'h68;  // low three bits pick the bank register
  localparam logic [7:0] OP_XOR_A_DIR = 8'h65;
  localparam logic [7:0] OP_XOR_A_PTR = 8'h66;  // low bit picks the pointer register
  localparam logic [7:0] OP_XOR_A_IMM = 8'h64;
  localparam logic [7:0] OP_XOR_DIR_A = 8'h62;
  localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
  // ----------------------------------------------------------------
  // arithmetic op selects on the alu command port
  // ----------------------------------------------------------------
  localparam logic [1:0] ALU_XOR = 2'h0;
  localparam logic [1:0] ALU_ADD_WITH_CARRY = 2'h1;
  localparam logic [1:0] ALU_SUBTRACT_WITH_BORROW = 2'h2;
  localparam logic [1:0] ALU_DIVIDE = 2'h3;
  // ----------------------------------------------------------------
  // lengths, cycle counts, zero byte and port base
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PORT_BASE = 8'h80;  // direct addresses at or above this are hardware
endpackage

// ===== xor_alu_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the xor and carry datapath
// ----------------------------------------------------------------
module xor_alu_props (
  input wire logic I_CLK, I_SRST, I_CE, I_XOR_START, I_ALU_START, I_CARRY,
  input wire logic [7:0] I_OPCODE, I_DIRECT_ADDR, I_IMM, I_ACC, I_BANK_REGISTER,
  input wire logic [7:0] I_POINTER_DATA, I_DIRECT_DATA, I_PORT_LATCH, I_OPERAND,
  input wire logic [7:0] I_AUX_REG, O_ACC, O_AUX_REG, O_DIRECT_WDATA, O_DIRECT_WADDR,
  input wire logic [1:0] I_ALU_OP, O_LENGTH, O_CYCLES,
  input wire logic [2:0] O_BANK_SEL,
  input wire logic O_ACC_WE, O_AUX_WE, O_DIRECT_WE, O_POINTER_SEL, O_CARRY, O_OVF,
  input wire logic O_FLAGS_WE, O_DONE, O_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  logic xgo, ago, xok;
  logic [7:0] a_r, b_r, x_r;
  logic c_r;
  // accepted starts: xor needs a valid opcode and wins over alu
  assign xok = I_OPCODE[7:4] == 4'h6 && I_OPCODE[3:0] > 4'h1;
  assign xgo = I_CE && !O_BUSY && I_XOR_START && xok;
  assign ago = I_CE && !O_BUSY && I_ALU_START && !(I_XOR_START && xok);
  // operands seen at the start edge
  always_ff @(posedge I_CLK) begin
    a_r <= I_ACC;
    b_r <= I_OPERAND;
    x_r <= I_AUX_REG;
    c_r <= I_CARRY;
  end
  sequence s_hold;
    O_BUSY && !O_DONE && !O_DIRECT_WE && O_CYCLES == 2'h2 && O_LENGTH == 2'h3;
  endsequence
  sequence s_write;
    O_DONE && O_DIRECT_WE && !O_BUSY
      && O_DIRECT_WDATA == ($past(I_DIRECT_DATA, 2) ^ $past(I_IMM, 2));
  endsequence
  property p_bank;
    xgo && I_OPCODE[7:3] == 5'h0d |=> O_ACC_WE && O_DONE && O_LENGTH == 2'h1
      && O_CYCLES == 2'h1 && O_ACC == (a_r ^ $past(I_BANK_REGISTER))
      && O_BANK_SEL == 3'($past(I_OPCODE));
  endproperty
  property p_dir;
    xgo && I_OPCODE == 8'h65 && I_DIRECT_ADDR < 8'h80 |=> O_ACC_WE && O_LENGTH == 2'h2
      && O_CYCLES == 2'h1 && O_ACC == (a_r ^ $past(I_DIRECT_DATA));
  endproperty
  property p_ptr;
    xgo && I_OPCODE[7:1] == 7'h33 |=> O_ACC == (a_r ^ $past(I_POINTER_DATA))
      && O_POINTER_SEL == 1'($past(I_OPCODE));
  endproperty
  property p_dir_a;
    xgo && I_OPCODE == 8'h62 && I_DIRECT_ADDR < 8'h80 |=> O_DIRECT_WE && O_LENGTH == 2'h2
      && O_DIRECT_WADDR == $past(I_DIRECT_ADDR) && O_DIRECT_WDATA == (a_r ^ $past(I_DIRECT_DATA));
  endproperty
  property p_imm;
    xgo && I_OPCODE == 8'h63 && I_DIRECT_ADDR < 8'h80 |=> s_hold ##1 s_write;
  endproperty
  property p_port;
    xgo && I_OPCODE == 8'h62 && I_DIRECT_ADDR >= 8'h80 |=>
      O_DIRECT_WDATA == (a_r ^ $past(I_PORT_LATCH));
  endproperty
  property p_flags;
    xgo |=> !O_FLAGS_WE && $stable(O_CARRY) && $stable(O_OVF);
  endproperty
  property p_add;
    ago && I_ALU_OP == 2'h1 |=> O_FLAGS_WE && {O_CARRY, O_ACC} == {1'b0, a_r} + {1'b0, b_r}
      + {8'h00, c_r} && O_OVF == (a_r[7] == b_r[7] && O_ACC[7] != a_r[7]);
  endproperty
  property p_sub;
    ago && I_ALU_OP == 2'h2 |=> O_FLAGS_WE && {O_CARRY, O_ACC} == {1'b0, a_r} - {1'b0, b_r}
      - {8'h00, c_r} && O_OVF == (a_r[7] != b_r[7] && O_ACC[7] != a_r[7]);
  endproperty
  property p_div;
    ago && I_ALU_OP == 2'h3 && I_AUX_REG != 8'h00 |=> O_ACC_WE && O_AUX_WE
      && O_ACC == a_r / x_r && O_AUX_REG == a_r % x_r && !O_CARRY && !O_OVF && O_FLAGS_WE;
  endproperty
  a_bank: assert property (p_bank) else $error("bank xor wrong");
  a_dir: assert property (p_dir) else $error("direct xor wrong");
  a_ptr: assert property (p_ptr) else $error("pointer xor wrong");
  a_dir_a: assert property (p_dir_a) else $error("direct write wrong");
  a_imm: assert property (p_imm) else $error("two cycle xor wrong");
  a_port: assert property (p_port) else $error("port latch not used");
  a_flags: assert property (p_flags) else $error("xor wrote flags");
  a_add: assert property (p_add) else $error("add with carry wrong");
  a_sub: assert property (p_sub) else $error("subtract wrong");
  a_div: assert property (p_div) else $error("divide wrong");
endmodule

bind xor_and_carry_alu xor_alu_props props (.*);

// ===== xor_and_carry_alu.sv
`timescale 1ns/1ps
// Function
// - accumulator xor bank register, one byte, one cycle.
// - accumulator xor direct byte, two bytes, one cycle.
// - accumulator xor pointer-addressed ram, pointer chosen by opcode bit 0.
// - direct byte xor accumulator written back to direct, two bytes, one cycle.
// - direct byte xor immediate, three bytes, two cycles.
// - add and subtract include previous carry for chaining.
// - carry set on unsigned overflow or underflow, else cleared.
// - signed range flag reports signed overflow of whole string.
// - divide leaves quotient in accumulator, remainder in auxiliary register.
// - every xor form stores bitwise xor and leaves flags unchanged.
// - xor on output port reads port latch, not pins.
module xor_and_carry_alu (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire logic I_XOR_START,
  input wire logic [7:0] I_OPCODE,
  input wire logic [7:0] I_DIRECT_ADDR,
  input wire logic [7:0] I_IMM,
  input wire logic [7:0] I_ACC,
  input wire logic [7:0] I_BANK_REGISTER,
  input wire logic [7:0] I_POINTER_DATA,
  input wire logic [7:0] I_DIRECT_DATA,
  input wire logic [7:0] I_PORT_LATCH,
  input wire logic I_ALU_START,
  input wire logic [1:0] I_ALU_OP,
  input wire logic [7:0] I_OPERAND,
  input wire logic [7:0] I_AUX_REG,
  input wire logic I_CARRY,
  input wire logic I_OVF,
  input wire logic I_AUX_CARRY,
  output logic [7:0] O_ACC,
  output logic O_ACC_WE,
  output logic [7:0] O_AUX_REG,
  output logic O_AUX_WE,
  output logic [7:0] O_DIRECT_WDATA,
  output logic [7:0] O_DIRECT_WADDR,
  output logic O_DIRECT_WE,
  output logic O_POINTER_SEL,
  output logic [2:0] O_BANK_SEL,
  output logic O_CARRY,
  output logic O_AUX_CARRY,
  output logic O_OVF,
  output logic O_FLAGS_WE,
  output logic [1:0] O_LENGTH,
  output logic [1:0] O_CYCLES,
  output logic O_DONE,
  output logic O_BUSY
);
  typedef enum logic [0:0] {IDLE, SECOND} state_t;
  state_t state_r;
  logic [7:0] xsrc;
  logic [7:0] xdst;
  logic to_acc;
  logic valid;
  logic [1:0] len;
  logic two_cyc;
  logic [7:0] held_r;
  logic [7:0] addr_r;
  logic [7:0] ar_res;
  logic [7:0] ar_aux;
  logic ar_c;
  logic ar_ac;
  logic ar_ov;
  logic [7:0] dir_val;
  // --------------------------------------------------------------
  // xor form decode
  // --------------------------------------------------------------
  always_comb begin
    dir_val = (I_DIRECT_ADDR >= xor_alu_pkg::PORT_BASE) ? I_PORT_LATCH : I_DIRECT_DATA;
    xsrc = 8'h00;
    xdst = I_ACC;
    to_acc = 1'b1;
    valid = 1'b1;
    len = xor_alu_pkg::LEN_ONE;
    two_cyc = 1'b0;
    if ((I_OPCODE & 8'hf8) == xor_alu_pkg::OP_XOR_A_BANK) begin
      xsrc = I_BANK_REGISTER;
    end else if ((I_OPCODE & 8'hfe) == xor_alu_pkg::OP_XOR_A_PTR) begin
      xsrc = I_POINTER_DATA;
    end else begin
      case (I_OPCODE)
        xor_alu_pkg::OP_XOR_A_DIR: begin
          xsrc = dir_val;
          len = xor_alu_pkg::LEN_TWO;
        end
        xor_alu_pkg::OP_XOR_A_IMM: begin
          xsrc = I_IMM;
          len = xor_alu_pkg::LEN_TWO;
        end
        xor_alu_pkg::OP_XOR_DIR_A: begin
          xsrc = I_ACC;
          xdst = dir_val;
          to_acc = 1'b0;
          len = xor_alu_pkg::LEN_TWO;
        end
        xor_alu_pkg::OP_XOR_DIR_IMM: begin
          xsrc = I_IMM;
          xdst = dir_val;
          to_acc = 1'b0;
          len = xor_alu_pkg::LEN_THREE;
          two_cyc = 1'b1;
        end
        default: begin
          valid = 1'b0;
        end
      endcase
    end
  end
  // --------------------------------------------------------------
  // arithmetic unit
  // --------------------------------------------------------------
  byte_arith u_arith (
    .i_op(I_ALU_OP),
    .i_a(I_ACC),
    .i_b(I_ALU_OP == xor_alu_pkg::ALU_DIVIDE ? I_AUX_REG : I_OPERAND),
    .i_carry(I_CARRY),
    .o_res(ar_res),
    .o_aux(ar_aux),
    .o_carry(ar_c),
    .o_aux_carry(ar_ac),
    .o_ovf(ar_ov)
  );
  // --------------------------------------------------------------
  // sequencing and outputs
  // --------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_r <= IDLE;
      held_r <= 8'h00;
      addr_r <= 8'h00;
      O_ACC <= 8'h00;
      O_ACC_WE <= 1'b0;
      O_AUX_REG <= 8'h00;
      O_AUX_WE <= 1'b0;
      O_DIRECT_WDATA <= 8'h00;
      O_DIRECT_WADDR <= 8'h00;
      O_DIRECT_WE <= 1'b0;
      O_POINTER_SEL <= 1'b0;
      O_BANK_SEL <= 3'h0;
      O_CARRY <= 1'b0;
      O_AUX_CARRY <= 1'b0;
      O_OVF <= 1'b0;
      O_FLAGS_WE <= 1'b0;
      O_LENGTH <= 2'h0;
      O_CYCLES <= 2'h0;
      O_DONE <= 1'b0;
      O_BUSY <= 1'b0;
    end else if (I_CE) begin
      O_ACC_WE <= 1'b0;
      O_AUX_WE <= 1'b0;
      O_DIRECT_WE <= 1'b0;
      O_FLAGS_WE <= 1'b0;
      O_DONE <= 1'b0;
      case (state_r)
        IDLE: begin
          if (I_XOR_START && valid) begin
            O_POINTER_SEL <= I_OPCODE[0];
            O_BANK_SEL <= I_OPCODE[2:0];
            O_LENGTH <= len;
            O_FLAGS_WE <= 1'b0;
            if (two_cyc) begin
              held_r <= xdst ^ xsrc;
              addr_r <= I_DIRECT_ADDR;
              O_CYCLES <= xor_alu_pkg::CYC_TWO;
              O_BUSY <= 1'b1;
              state_r <= SECOND;
            end else begin
              O_CYCLES <= xor_alu_pkg::CYC_ONE;
              O_DONE <= 1'b1;
              if (to_acc) begin
                O_ACC <= xdst ^ xsrc;
                O_ACC_WE <= 1'b1;
              end else begin
                O_DIRECT_WDATA <= xdst ^ xsrc;
                O_DIRECT_WADDR <= I_DIRECT_ADDR;
                O_DIRECT_WE <= 1'b1;
              end
            end
          end else if (I_ALU_START) begin
            O_CYCLES <= xor_alu_pkg::CYC_ONE;
            O_DONE <= 1'b1;
            O_ACC <= ar_res;
            O_ACC_WE <= 1'b1;
            if (I_ALU_OP == xor_alu_pkg::ALU_XOR) begin
              O_CARRY <= I_CARRY;
              O_AUX_CARRY <= I_AUX_CARRY;
              O_OVF <= I_OVF;
            end else begin
              O_CARRY <= ar_c;
              O_AUX_CARRY <= (I_ALU_OP == xor_alu_pkg::ALU_DIVIDE) ? I_AUX_CARRY : ar_ac;
              O_OVF <= ar_ov;
              O_FLAGS_WE <= 1'b1;
            end
            if (I_ALU_OP == xor_alu_pkg::ALU_DIVIDE) begin
              O_AUX_REG <= ar_aux;
              O_AUX_WE <= 1'b1;
            end
          end
        end
        SECOND: begin
          O_DIRECT_WDATA <= held_r;
          O_DIRECT_WADDR <= addr_r;
          O_DIRECT_WE <= 1'b1;
          O_DONE <= 1'b1;
          O_BUSY <= 1'b0;
          state_r <= IDLE;
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end
endmodule

// ===== xor_and_carry_alu_tb.sv
`timescale 1ns/1ps
module xor_and_carry_alu_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic I_CLK = 0, I_SRST = 1, I_CE = 1, I_XOR_START = 0, I_ALU_START = 0;
  logic I_CARRY = 0, I_OVF = 0, I_AUX_CARRY = 0;
  logic [1:0] I_ALU_OP = 0;
  logic [7:0] I_OPCODE = 0, I_DIRECT_ADDR = 0, I_IMM = 0, I_ACC = 0, I_BANK_REGISTER = 0;
  logic [7:0] I_POINTER_DATA = 0, I_DIRECT_DATA = 0, I_PORT_LATCH = 0, I_OPERAND = 0;
  logic [7:0] I_AUX_REG = 0, O_ACC, O_AUX_REG, O_DIRECT_WDATA, O_DIRECT_WADDR;
  logic [1:0] O_LENGTH, O_CYCLES;
  logic [2:0] O_BANK_SEL;
  logic O_ACC_WE, O_AUX_WE, O_DIRECT_WE, O_POINTER_SEL, O_CARRY, O_AUX_CARRY, O_OVF;
  logic O_FLAGS_WE, O_DONE, O_BUSY;
  int errors = 0;
  int tests_run = 0;
  int waits;
  xor_and_carry_alu DUT (.*);
  // core clock, 40 ns period
  initial begin
    forever #20 I_CLK = ~I_CLK;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic ck(input string s, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one start pulse, then wait for done under a bound; called at a falling edge
  // an idle cycle first, so a start never drops and rises in one time step
  task automatic go(input logic xs, input logic [7:0] opc, input logic [1:0] aop);
    @(negedge I_CLK);
    I_XOR_START = xs;
    I_ALU_START = !xs;
    I_OPCODE = opc;
    I_ALU_OP = aop;
    @(negedge I_CLK);
    I_XOR_START = 0;
    I_ALU_START = 0;
    waits = 0;
    while (O_DONE !== 1'b1 && waits < 4) begin
      @(negedge I_CLK);
      waits++;
    end
    if (waits == 4) begin
      errors++;
      stop_test;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bank;
    for (int i = 0; i < 8; i++) begin
      I_ACC = 8'hc3;
      I_BANK_REGISTER = 8'(8'ha8 + i);
      go(1, 8'(8'h68 + i), 2'h0);
      ck("acc", O_ACC, 8'hc3 ^ 8'(8'ha8 + i));
      ck("bank_sel", O_BANK_SEL, 16'(i));
      ck("len_cyc", {O_LENGTH, O_CYCLES}, 4'h5);
      ck("flags_we", O_FLAGS_WE, 1'b0);
    end
    $display("bank test done");
  endtask
  task automatic t_src;
    I_ACC = 8'h5a;
    I_DIRECT_ADDR = 8'h30;
    I_DIRECT_DATA = 8'h0f;
    I_POINTER_DATA = 8'h3c;
    I_IMM = 8'hff;
    go(1, 8'h65, 2'h0);
    ck("acc", O_ACC, 8'h55);
    ck("len_cyc", {O_LENGTH, O_CYCLES}, 4'h9);
    go(1, 8'h66, 2'h0);
    ck("acc", O_ACC, 8'h66);
    ck("ptr_sel", O_POINTER_SEL, 1'b0);
    go(1, 8'h67, 2'h0);
    ck("ptr_sel", O_POINTER_SEL, 1'b1);
    go(1, 8'h64, 2'h0);
    ck("acc", O_ACC, 8'ha5);
    $display("source test done");
  endtask
  task automatic t_dst;
    go(1, 8'h62, 2'h0);
    ck("wdata", O_DIRECT_WDATA, 8'h55);
    ck("waddr_we", {O_DIRECT_WADDR, O_DIRECT_WE}, 9'h061);
    I_DIRECT_ADDR = 8'h90;
    I_PORT_LATCH = 8'h34;
    I_DIRECT_DATA = 8'hcb;
    I_IMM = 8'h31;
    go(1, 8'h63, 2'h0);
    ck("wdata", O_DIRECT_WDATA, 8'h05);
    ck("len_cyc", {O_LENGTH, O_CYCLES}, 4'he);
    ck("waits", 16'(waits), 16'h0001);
    I_DIRECT_ADDR = 8'h30;
    go(1, 8'h63, 2'h0);
    ck("wdata", O_DIRECT_WDATA, 8'hfa);
    ck("waddr_we", {O_DIRECT_WADDR, O_DIRECT_WE}, 9'h061);
    I_DIRECT_ADDR = 8'h90;
    go(1, 8'h62, 2'h0);
    ck("wdata", O_DIRECT_WDATA, 8'h6e);
    go(1, 8'h65, 2'h0);
    ck("acc", O_ACC, 8'h6e);
    $display("destination test done");
  endtask
  task automatic t_arith;
    I_ACC = 8'hff;
    I_OPERAND = 8'h01;
    go(0, 8'h00, 2'h1);
    ck("carry_acc", {O_CARRY, O_ACC}, 9'h100);
    ck("aux_we", {O_AUX_CARRY, O_FLAGS_WE}, 2'h3);
    I_CARRY = O_CARRY;
    I_ACC = 8'h12;
    go(0, 8'h00, 2'h1);
    ck("carry_acc", {O_CARRY, O_ACC}, 9'h014);
    I_CARRY = 0;
    I_ACC = 8'h7f;
    go(0, 8'h00, 2'h1);
    ck("ovf_carry_acc", {O_OVF, O_CARRY, O_ACC}, 10'h280);
    I_CARRY = 1;
    I_ACC = 8'hc9;
    I_OPERAND = 8'h54;
    go(0, 8'h00, 2'h2);
    ck("ovf_carry_acc", {O_OVF, O_CARRY, O_ACC}, 10'h274);
    ck("aux_carry", O_AUX_CARRY, 1'b0);
    I_CARRY = 0;
    I_ACC = 8'h00;
    I_OPERAND = 8'h01;
    go(0, 8'h00, 2'h2);
    ck("ovf_carry_acc", {O_OVF, O_CARRY, O_ACC}, 10'h1ff);
    $display("carry test done");
  endtask
  task automatic t_div;
    I_ACC = 8'h59;
    I_AUX_REG = 8'h10;
    go(0, 8'h00, 2'h3);
    ck("quot_rem", {O_ACC, O_AUX_REG}, 16'h0509);
    ck("acc_aux_we", {O_ACC_WE, O_AUX_WE}, 2'h3);
    I_AUX_REG = 8'h00;
    go(0, 8'h00, 2'h3);
    ck("div_zero", {O_OVF, O_CARRY, O_ACC}, 10'h259);
    $display("divide test done");
  endtask
  task automatic t_alu_xor;
    I_ACC = 8'h3c;
    I_OPERAND = 8'h0f;
    I_CARRY = 1;
    I_OVF = 1;
    I_AUX_CARRY = 1;
    go(0, 8'h00, 2'h0);
    ck("acc", O_ACC, 8'h33);
    ck("flags", {O_OVF, O_CARRY, O_AUX_CARRY, O_FLAGS_WE}, 4'he);
    I_CARRY = 0;
    I_OVF = 0;
    I_AUX_CARRY = 0;
    $display("alu xor test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge I_CLK);
    I_SRST = 0;
    t_bank;
    t_src;
    t_dst;
    t_arith;
    t_div;
    t_alu_xor;
    stop_test;
  end
endmodule
